// *** hdl/fcp_defines.svh ***
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// bus and field widths
`define FCP_DATA_W 36
`define FCP_CFG_W 8
`define FCP_AXI_AW 8
`define FCP_AXI_DW 32
`define FCP_EV_W 4

// register byte addresses
`define FCP_REG_STATUS 8'h00
`define FCP_REG_INT_CLEAR 8'h04
`define FCP_REG_INT_ENABLE 8'h08
`define FCP_REG_LEVEL 8'h0c
`define FCP_REG_OFFSETS 8'h10

// event bit positions in status, clear and enable
`define FCP_EV_FULL 0
`define FCP_EV_EMPTY 1
`define FCP_EV_OVERFLOW 2
`define FCP_EV_UNDERFLOW 3

// offsets register field layout
`define FCP_OFF_AE_LSB 0
`define FCP_OFF_AF_LSB 8

// configuration defaults after master reset
`define FCP_AE_DEFAULT 8'h02
`define FCP_AF_DEFAULT 8'h02

// axi responses
`define FCP_RESP_OKAY 2'b00
`define FCP_RESP_SLVERR 2'b10

`endif

// *** hdl/fcp_pkg.sv ***
`include "fcp_defines.svh"

package fcp_pkg;
	typedef logic [`FCP_DATA_W-1:0] fcp_word_t;
	typedef logic [`FCP_CFG_W-1:0] fcp_offset_t;
	typedef logic [`FCP_AXI_AW-1:0] fcp_addr_t;
	typedef logic [`FCP_AXI_DW-1:0] fcp_bus_t;
	typedef logic [`FCP_EV_W-1:0] fcp_ev_t;
	// which offset register the next parallel config access hits
	typedef enum logic [1:0] {FCP_CFG_AE = 2'b01, FCP_CFG_AF = 2'b10} fcp_cfg_sel_e;
endpackage

// *** hdl/fcp_store.sv ***
`timescale 1ns/100ps
`include "fcp_defines.svh"

module fcp_store #(
	parameter int WIDTH = `FCP_DATA_W,
	parameter int ADDR_W = 4
) (
	// clock
	input wire logic ref_clk,
	// write side
	input wire logic wr_store,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

	// no reset on the array: contents are only meaningful behind the pointers
	always_ff @(posedge ref_clk)
	begin
		if (wr_store)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// asynchronous read, the top registers the word
	assign rd_data = mem[rd_addr];
endmodule

// *** hdl/fcp_top.sv ***
// Notes on behaviour
// RQ1 - separate 36-bit data input bus and 36-bit data output bus
// RQ2 - writes happen only on a clock edge with write enable asserted
// RQ3 - reads happen only on a clock edge with read enable asserted
// RQ4 - enabled write always advances write pointer; data stored only if input enabled (a write at full is refused here and leaves the pointer alone)
// RQ5 - outputs driven while output enable low, released while it is high
// RQ6 - config select low hits offset registers via low byte; high hits buffer
// RQ7 - empty flag goes low when buffer holds no words
// RQ8 - full flag goes low when buffer has no free location
// RQ9 - almost-empty flag low when fill level reaches almost-empty offset
// RQ10 - almost-full flag low when free space reaches almost-full offset
// RQ11 - retransmit reloads read pointer with the marked location
// RQ12 - after retransmit reads repeat old data until read pointer meets write
// RQ13 - master reset clears pointers, output, flags and restores configuration
// RQ14 - partial reset clears pointers, output, flags but keeps configuration
// RQ15 - serial clock rising edge with enable shifts serial bit into offsets
// RQ16 - mark records the current read pointer for later retransmits
// RQ17 - serial offset loading only while serial enable is active
// RQ18 - pointers compared safely before flags are computed
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "fcp_defines.svh"

module fcp_top #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// write port
	input wire logic write_enable_n,
	input wire logic input_enable_n,
	input wire fcp_pkg::fcp_word_t data_in,
	// read port
	input wire logic read_enable_n,
	input wire logic output_enable_n,
	input wire logic mark,
	input wire logic retransmit,
	output fcp_pkg::fcp_word_t data_out,
	output logic data_out_oe,
	// shared control
	input wire logic config_select_n,
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	// serial offset programming
	input wire logic serial_prog_clk,
	input wire logic serial_prog_enable,
	input wire logic serial_prog_data,
	// flags
	output logic empty_flag_n,
	output logic full_flag_n,
	output logic almost_empty_flag_n,
	output logic almost_full_flag_n,
	// axi4-lite write
	input wire fcp_pkg::fcp_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire fcp_pkg::fcp_bus_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire fcp_pkg::fcp_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output fcp_pkg::fcp_bus_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq
);
	import fcp_pkg::*;

	localparam int PW = ADDR_W + 1;
	localparam logic [PW-1:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};

	// fill level from two wrap-extended pointers
	function automatic logic [PW-1:0] fill_of(input logic [PW-1:0] w, input logic [PW-1:0] r);
		fill_of = w - r;
	endfunction

	// register map hits
	function automatic logic is_mapped(input fcp_addr_t a);
		is_mapped = (a == `FCP_REG_STATUS) || (a == `FCP_REG_INT_CLEAR) ||
			(a == `FCP_REG_INT_ENABLE) || (a == `FCP_REG_LEVEL) || (a == `FCP_REG_OFFSETS);
	endfunction

	// fifo state
	logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr_ff, rd_ptr_ff, nxt_rd_ptr_ff;
	logic [PW-1:0] mark_ptr_ff, nxt_mark_ptr_ff;
	fcp_word_t data_out_ff, nxt_data_out_ff;
	logic data_oe_ff, nxt_data_oe_ff;
	logic empty_n_ff, nxt_empty_n_ff, full_n_ff, nxt_full_n_ff;
	logic ae_n_ff, nxt_ae_n_ff, af_n_ff, nxt_af_n_ff;
	// configuration state
	fcp_offset_t ae_off_ff, nxt_ae_off_ff, af_off_ff, nxt_af_off_ff;
	fcp_cfg_sel_e wr_sel_ff, nxt_wr_sel_ff, rd_sel_ff, nxt_rd_sel_ff;
	logic sclk_q_ff, nxt_sclk_q_ff;
	// bus slave state
	logic aw_held_ff, nxt_aw_held_ff, w_held_ff, nxt_w_held_ff;
	fcp_addr_t aw_addr_ff, nxt_aw_addr_ff;
	fcp_bus_t w_data_ff, nxt_w_data_ff;
	logic [3:0] w_strb_ff, nxt_w_strb_ff;
	logic awready_ff, nxt_awready_ff, wready_ff, nxt_wready_ff;
	logic bvalid_ff, nxt_bvalid_ff, arready_ff, nxt_arready_ff, rvalid_ff, nxt_rvalid_ff;
	logic [1:0] bresp_ff, nxt_bresp_ff, rresp_ff, nxt_rresp_ff;
	fcp_bus_t rdata_ff, nxt_rdata_ff;
	// interrupt state
	fcp_ev_t status_ff, nxt_status_ff, enable_ff, nxt_enable_ff;
	logic irq_ff, nxt_irq_ff;

	// shared combinational terms
	logic any_reset, fill_full, fill_empty, wr_do, rd_do, cfg_wr, cfg_rd;
	logic reg_wr, sclk_rise;
	logic [PW-1:0] fill_now, fill_nxt;
	fcp_word_t store_q;
	fcp_ev_t events;

	// pointer difference is safe here: both ports share ref_clk
	assign fill_now = fill_of(wr_ptr_ff, rd_ptr_ff); // RQ18
	assign fill_full = (fill_now == DEPTH);
	assign fill_empty = (fill_now == {PW{1'b0}});
	assign any_reset = ~master_reset_n | ~partial_reset_n;
	// refused writes at full and reads at empty leave the pointers alone
	assign wr_do = ~write_enable_n & config_select_n & ~fill_full & ~any_reset; // RQ2 RQ6
	assign rd_do = ~read_enable_n & config_select_n & ~fill_empty & ~retransmit & ~any_reset; // RQ3 RQ6
	assign cfg_wr = ~write_enable_n & ~config_select_n; // RQ2 RQ6
	assign cfg_rd = ~read_enable_n & ~config_select_n; // RQ3 RQ6
	assign reg_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign sclk_rise = serial_prog_clk & ~sclk_q_ff;

	fcp_store #(
		.WIDTH(`FCP_DATA_W),
		.ADDR_W(ADDR_W)
	) u_store (
		.ref_clk(ref_clk),
		.wr_store(wr_do & ~input_enable_n), // RQ4
		.wr_addr(wr_ptr_ff[ADDR_W-1:0]),
		.wr_data(data_in), // RQ1
		.rd_addr(rd_ptr_ff[ADDR_W-1:0]),
		.rd_data(store_q)
	);

	// fifo pointers, output word and flags
	always_comb
	begin
		nxt_wr_ptr_ff = wr_ptr_ff;
		nxt_rd_ptr_ff = rd_ptr_ff;
		nxt_mark_ptr_ff = mark_ptr_ff;
		nxt_data_out_ff = data_out_ff;
		nxt_data_oe_ff = ~output_enable_n; // RQ5
		if (wr_do)
		begin
			nxt_wr_ptr_ff = wr_ptr_ff + 1'b1; // RQ4
		end
		if (mark)
		begin
			nxt_mark_ptr_ff = rd_ptr_ff; // RQ16
		end
		if (retransmit)
		begin
			nxt_rd_ptr_ff = mark_ptr_ff; // RQ11
		end
		else if (rd_do)
		begin
			nxt_data_out_ff = store_q;
			nxt_rd_ptr_ff = rd_ptr_ff + 1'b1; // RQ12
		end
		else if (cfg_rd)
		begin
			nxt_data_out_ff = '0;
			nxt_data_out_ff[`FCP_CFG_W-1:0] = (rd_sel_ff == FCP_CFG_AE) ? ae_off_ff : af_off_ff; // RQ6
		end
		if (any_reset)
		begin
			nxt_wr_ptr_ff = '0; // RQ13 RQ14
			nxt_rd_ptr_ff = '0; // RQ13 RQ14
			nxt_mark_ptr_ff = '0;
			nxt_data_out_ff = '0; // RQ13 RQ14
		end
	end

	// flags follow the next pointers so they never lag a transfer
	always_comb
	begin
		fill_nxt = fill_of(nxt_wr_ptr_ff, nxt_rd_ptr_ff); // RQ18
		nxt_empty_n_ff = (fill_nxt != {PW{1'b0}}); // RQ7
		nxt_full_n_ff = (fill_nxt != DEPTH); // RQ8
		// compare wide: an offset above the depth must not wrap into a small one
		nxt_ae_n_ff = (32'(fill_nxt) > 32'(ae_off_ff)); // RQ9
		nxt_af_n_ff = (32'(DEPTH - fill_nxt) > 32'(af_off_ff)); // RQ10
		events = '0;
		events[`FCP_EV_FULL] = full_n_ff & ~nxt_full_n_ff;
		events[`FCP_EV_EMPTY] = empty_n_ff & ~nxt_empty_n_ff;
		events[`FCP_EV_OVERFLOW] = ~write_enable_n & config_select_n & fill_full;
		events[`FCP_EV_UNDERFLOW] = ~read_enable_n & config_select_n & fill_empty;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			mark_ptr_ff <= '0;
			data_out_ff <= '0;
			data_oe_ff <= 1'b0;
			empty_n_ff <= 1'b0;
			full_n_ff <= 1'b1;
			ae_n_ff <= 1'b0;
			af_n_ff <= 1'b1;
		end
		else
		begin
			wr_ptr_ff <= nxt_wr_ptr_ff;
			rd_ptr_ff <= nxt_rd_ptr_ff;
			mark_ptr_ff <= nxt_mark_ptr_ff;
			data_out_ff <= nxt_data_out_ff;
			data_oe_ff <= nxt_data_oe_ff;
			empty_n_ff <= nxt_empty_n_ff;
			full_n_ff <= nxt_full_n_ff;
			ae_n_ff <= nxt_ae_n_ff;
			af_n_ff <= nxt_af_n_ff;
		end
	end

	// offset registers: parallel, bus and serial loading
	always_comb
	begin
		nxt_ae_off_ff = ae_off_ff;
		nxt_af_off_ff = af_off_ff;
		nxt_wr_sel_ff = wr_sel_ff;
		nxt_rd_sel_ff = rd_sel_ff;
		nxt_sclk_q_ff = serial_prog_clk;
		// serial chain runs almost-full then almost-empty, msb first
		if (sclk_rise && serial_prog_enable)
		begin
			{nxt_af_off_ff, nxt_ae_off_ff} = {af_off_ff[`FCP_CFG_W-2:0], ae_off_ff,
				serial_prog_data}; // RQ15 RQ17
		end
		if (reg_wr && aw_addr_ff == `FCP_REG_OFFSETS)
		begin
			if (w_strb_ff[0])
			begin
				nxt_ae_off_ff = w_data_ff[`FCP_OFF_AE_LSB +: `FCP_CFG_W];
			end
			if (w_strb_ff[1])
			begin
				nxt_af_off_ff = w_data_ff[`FCP_OFF_AF_LSB +: `FCP_CFG_W];
			end
		end
		// parallel loads alternate between the two offsets
		if (cfg_wr)
		begin
			if (wr_sel_ff == FCP_CFG_AE)
			begin
				nxt_ae_off_ff = data_in[`FCP_CFG_W-1:0]; // RQ6
				nxt_wr_sel_ff = FCP_CFG_AF;
			end
			else
			begin
				nxt_af_off_ff = data_in[`FCP_CFG_W-1:0]; // RQ6
				nxt_wr_sel_ff = FCP_CFG_AE;
			end
		end
		if (cfg_rd)
		begin
			case (rd_sel_ff)
				FCP_CFG_AE: nxt_rd_sel_ff = FCP_CFG_AF;
				FCP_CFG_AF: nxt_rd_sel_ff = FCP_CFG_AE;
				default: nxt_rd_sel_ff = FCP_CFG_AE;
			endcase
		end
		// only master reset touches configuration
		if (!master_reset_n)
		begin
			nxt_ae_off_ff = `FCP_AE_DEFAULT; // RQ13
			nxt_af_off_ff = `FCP_AF_DEFAULT; // RQ13
			nxt_wr_sel_ff = FCP_CFG_AE;
			nxt_rd_sel_ff = FCP_CFG_AE;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ae_off_ff <= `FCP_AE_DEFAULT;
			af_off_ff <= `FCP_AF_DEFAULT;
			wr_sel_ff <= FCP_CFG_AE;
			rd_sel_ff <= FCP_CFG_AE;
			sclk_q_ff <= 1'b0;
		end
		else
		begin
			ae_off_ff <= nxt_ae_off_ff;
			af_off_ff <= nxt_af_off_ff;
			wr_sel_ff <= nxt_wr_sel_ff;
			rd_sel_ff <= nxt_rd_sel_ff;
			sclk_q_ff <= nxt_sclk_q_ff;
		end
	end

	// axi4-lite slave: one write and one read outstanding
	always_comb
	begin
		nxt_aw_held_ff = aw_held_ff;
		nxt_aw_addr_ff = aw_addr_ff;
		nxt_w_held_ff = w_held_ff;
		nxt_w_data_ff = w_data_ff;
		nxt_w_strb_ff = w_strb_ff;
		nxt_bvalid_ff = bvalid_ff;
		nxt_bresp_ff = bresp_ff;
		nxt_rvalid_ff = rvalid_ff;
		nxt_rdata_ff = rdata_ff;
		nxt_rresp_ff = rresp_ff;
		if (s_axi_awvalid && awready_ff)
		begin
			nxt_aw_held_ff = 1'b1;
			nxt_aw_addr_ff = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff)
		begin
			nxt_w_held_ff = 1'b1;
			nxt_w_data_ff = s_axi_wdata;
			nxt_w_strb_ff = s_axi_wstrb;
		end
		if (reg_wr)
		begin
			nxt_aw_held_ff = 1'b0;
			nxt_w_held_ff = 1'b0;
			nxt_bvalid_ff = 1'b1;
			nxt_bresp_ff = is_mapped(aw_addr_ff) ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
		end
		else if (bvalid_ff && s_axi_bready)
		begin
			nxt_bvalid_ff = 1'b0;
		end
		if (s_axi_arvalid && arready_ff)
		begin
			nxt_rvalid_ff = 1'b1;
			nxt_rresp_ff = is_mapped(s_axi_araddr) ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
			nxt_rdata_ff = '0;
			case (s_axi_araddr)
				`FCP_REG_STATUS: nxt_rdata_ff[`FCP_EV_W-1:0] = status_ff;
				`FCP_REG_INT_ENABLE: nxt_rdata_ff[`FCP_EV_W-1:0] = enable_ff;
				`FCP_REG_LEVEL: nxt_rdata_ff[PW-1:0] = fill_now;
				`FCP_REG_OFFSETS:
				begin
					nxt_rdata_ff[`FCP_OFF_AE_LSB +: `FCP_CFG_W] = ae_off_ff;
					nxt_rdata_ff[`FCP_OFF_AF_LSB +: `FCP_CFG_W] = af_off_ff;
				end
				default: nxt_rdata_ff = '0;
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			nxt_rvalid_ff = 1'b0;
		end
		// readies drop while a channel item is held or an answer waits
		nxt_awready_ff = ~nxt_aw_held_ff & ~nxt_bvalid_ff;
		nxt_wready_ff = ~nxt_w_held_ff & ~nxt_bvalid_ff;
		nxt_arready_ff = ~nxt_rvalid_ff;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_held_ff <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			arready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `FCP_RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= `FCP_RESP_OKAY;
			rdata_ff <= '0;
		end
		else
		begin
			aw_held_ff <= nxt_aw_held_ff;
			aw_addr_ff <= nxt_aw_addr_ff;
			w_held_ff <= nxt_w_held_ff;
			w_data_ff <= nxt_w_data_ff;
			w_strb_ff <= nxt_w_strb_ff;
			awready_ff <= nxt_awready_ff;
			wready_ff <= nxt_wready_ff;
			arready_ff <= nxt_arready_ff;
			bvalid_ff <= nxt_bvalid_ff;
			bresp_ff <= nxt_bresp_ff;
			rvalid_ff <= nxt_rvalid_ff;
			rresp_ff <= nxt_rresp_ff;
			rdata_ff <= nxt_rdata_ff;
		end
	end

	// sticky status; a new event beats a clear in the same cycle
	always_comb
	begin
		nxt_status_ff = status_ff;
		nxt_enable_ff = enable_ff;
		if (reg_wr && aw_addr_ff == `FCP_REG_INT_CLEAR && w_strb_ff[0])
		begin
			nxt_status_ff = status_ff & ~w_data_ff[`FCP_EV_W-1:0];
		end
		if (reg_wr && aw_addr_ff == `FCP_REG_INT_ENABLE && w_strb_ff[0])
		begin
			nxt_enable_ff = w_data_ff[`FCP_EV_W-1:0];
		end
		nxt_status_ff = nxt_status_ff | events;
		nxt_irq_ff = |(nxt_status_ff & nxt_enable_ff);
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_ff <= '0;
			enable_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			status_ff <= nxt_status_ff;
			enable_ff <= nxt_enable_ff;
			irq_ff <= nxt_irq_ff;
		end
	end

	// outputs straight from flip-flops
	assign data_out = data_out_ff; // RQ1
	assign data_out_oe = data_oe_ff; // RQ5
	assign empty_flag_n = empty_n_ff;
	assign full_flag_n = full_n_ff;
	assign almost_empty_flag_n = ae_n_ff;
	assign almost_full_flag_n = af_n_ff;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign irq = irq_ff;
endmodule

// *** verif/fcp_checker.sv ***
`timescale 1ns/100ps
module fcp_checker #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// controls
	input wire logic write_enable_n,
	input wire logic read_enable_n,
	input wire logic output_enable_n,
	input wire logic config_select_n,
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	// outputs
	input wire fcp_pkg::fcp_word_t data_out,
	input wire logic data_out_oe,
	input wire logic empty_flag_n,
	input wire logic full_flag_n,
	input wire logic almost_empty_flag_n,
	input wire logic almost_full_flag_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	import fcp_pkg::*;
	// one domain, so clock and disable are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	oe_follow_a: assert property (reset_n |=> data_out_oe == !$past(output_enable_n))
		else $error("output drive ignores enable");
	mrst_clear_a: assert property (!master_reset_n |=> data_out == '0 && !empty_flag_n
		&& !almost_empty_flag_n && full_flag_n) else $error("master reset incomplete");
	prst_clear_a: assert property (!partial_reset_n |=> data_out == '0 && !empty_flag_n
		&& full_flag_n) else $error("partial reset incomplete");
	write_fills_a: assert property (!write_enable_n && config_select_n && full_flag_n
		&& read_enable_n && master_reset_n && partial_reset_n |=> empty_flag_n)
		else $error("write left buffer empty");
	full_cause_a: assert property ($fell(full_flag_n) |-> !$past(write_enable_n))
		else $error("full without write");
	empty_cause_a: assert property ($fell(empty_flag_n) |-> !$past(read_enable_n)
		|| !$past(master_reset_n) || !$past(partial_reset_n)) else $error("empty without read");
	out_hold_a: assert property (read_enable_n && master_reset_n && partial_reset_n
		|=> $stable(data_out)) else $error("output moved without read");
	ae_empty_a: assert property (!empty_flag_n |-> !almost_empty_flag_n)
		else $error("almost empty off while empty");
	af_full_a: assert property (!full_flag_n |-> !almost_full_flag_n)
		else $error("almost full off while full");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule

bind fcp_top fcp_checker #(.ADDR_W(ADDR_W)) fcp_checker_i (.ref_clk, .reset_n,
	.write_enable_n, .read_enable_n, .output_enable_n, .config_select_n, .master_reset_n,
	.partial_reset_n, .data_out, .data_out_oe, .empty_flag_n, .full_flag_n,
	.almost_empty_flag_n, .almost_full_flag_n, .s_axi_bvalid, .s_axi_bready);

// *** verif/fcp_host.sv ***
`timescale 1ns/100ps
module fcp_host (
	// clock and read data
	input wire logic ref_clk,
	input wire fcp_pkg::fcp_word_t data_out,
	// writer and reader
	output logic write_enable_n,
	output logic input_enable_n,
	output fcp_pkg::fcp_word_t data_in,
	output logic read_enable_n,
	// serial programmer
	output logic serial_prog_clk,
	output logic serial_prog_enable,
	output logic serial_prog_data
);
	import fcp_pkg::*;
	// idle from time zero
	initial
	begin
		{write_enable_n, input_enable_n, read_enable_n} = 3'h7;
		{serial_prog_clk, serial_prog_enable, serial_prog_data} = 3'h0;
		data_in = '0;
	end
	// burst of n words, one per edge
	task automatic push(input fcp_word_t base, input int n, input logic in_en_n);
		// requests start just after a rising edge
		@(posedge ref_clk);
		for (int i = 0; i < n; i++)
		begin
			write_enable_n <= 1'h0;
			input_enable_n <= in_en_n;
			data_in <= base + fcp_word_t'(i);
			@(posedge ref_clk);
		end
		write_enable_n <= 1'h1;
		// a released bus must not look like the last word
		data_in <= ~data_in;
	endtask
	// burst of n reads, each word taken mid-cycle
	task automatic pop(input int n, output fcp_word_t q[$]);
		q = {};
		@(posedge ref_clk);
		read_enable_n <= 1'h0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk);
			if (i == n - 1)
				read_enable_n <= 1'h1;
			@(negedge ref_clk);
			q.push_back(data_out);
		end
	endtask
	// clock low for one sample, then high; stands still between frames
	task automatic shift(input logic [15:0] v, input int n, input logic en);
		@(posedge ref_clk);
		serial_prog_enable <= en;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_prog_clk <= 1'h0;
			serial_prog_data <= v[i];
			@(posedge ref_clk);
			serial_prog_clk <= 1'h1;
			@(posedge ref_clk);
		end
		serial_prog_clk <= 1'h0;
		serial_prog_enable <= 1'h0;
		serial_prog_data <= ~serial_prog_data;
	endtask
endmodule

// *** verif/test_dual_clock_fifo_port_control.sv ***
`timescale 1ns/100ps
`include "fcp_defines.svh"
module test_dual_clock_fifo_port_control;
	import fcp_pkg::*;
	logic ref_clk, reset_n = 1'h0, output_enable_n = 1'h0, mark = 1'h0, retransmit = 1'h0;
	logic config_select_n = 1'h1, master_reset_n = 1'h1, partial_reset_n = 1'h1;
	logic write_enable_n, input_enable_n, read_enable_n, data_out_oe, irq;
	logic serial_prog_clk, serial_prog_enable, serial_prog_data;
	logic empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
	fcp_word_t data_in, data_out, q[$];
	fcp_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
	fcp_bus_t s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int err_total, num_checks;
	wire [3:0] flags = {empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n};
	fcp_top #(.ADDR_W(4)) fcp_top_i (.ref_clk, .reset_n, .write_enable_n, .input_enable_n,
		.data_in, .read_enable_n, .output_enable_n, .mark, .retransmit, .data_out,
		.data_out_oe, .config_select_n, .master_reset_n, .partial_reset_n, .serial_prog_clk,
		.serial_prog_enable, .serial_prog_data, .empty_flag_n, .full_flag_n,
		.almost_empty_flag_n, .almost_full_flag_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	fcp_host fcp_host_i (.ref_clk, .data_out, .write_enable_n, .input_enable_n, .data_in,
		.read_enable_n, .serial_prog_clk, .serial_prog_enable, .serial_prog_data);
	initial
	begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic check(input fcp_word_t got, input fcp_word_t exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// each channel released once taken; bready held until bvalid seen
	task automatic axi_wr(input fcp_addr_t a, input fcp_bus_t d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		check(s_axi_bresp, `FCP_RESP_OKAY);
	endtask
	task automatic axi_rd(input fcp_addr_t a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic sync_rst(input logic whole);
		@(posedge ref_clk);
		if (whole)
			master_reset_n <= 1'h0;
		else
			partial_reset_n <= 1'h0;
		@(posedge ref_clk);
		{master_reset_n, partial_reset_n} <= 2'h3;
		@(negedge ref_clk);
		check(data_out, 36'h0);
		check(flags, 4'h5);
	endtask
	// flag ladder up to full and down to empty, with interrupt and status
	task automatic t_fill();
		axi_wr(`FCP_REG_INT_ENABLE, 32'h1 << `FCP_EV_FULL);
		for (int l = 1; l <= 17; l++)
		begin
			fcp_host_i.push(36'hc_3a5a_0000 + l, 1, 1'h0);
			@(negedge ref_clk);
			check(flags, {1'h1, l < 16, l > 2, l < 14});
		end
		check(irq, 1'h1);
		axi_rd(`FCP_REG_STATUS);
		check(rd, (32'h1 << `FCP_EV_FULL) | (32'h1 << `FCP_EV_OVERFLOW));
		axi_wr(`FCP_REG_INT_ENABLE, 32'h0);
		repeat (3) @(negedge ref_clk);
		check(irq, 1'h0);
		axi_wr(`FCP_REG_INT_CLEAR, 32'hf);
		axi_rd(`FCP_REG_STATUS);
		check(rd, 32'h0);
		axi_rd(8'h40);
		check(resp, `FCP_RESP_SLVERR);
		for (int l = 15; l >= 0; l--)
		begin
			fcp_host_i.pop(1, q);
			check(q[0], 36'hc_3a5a_0010 - l);
			check(flags, {l > 0, 1'h1, l > 2, l < 14});
		end
		$display("test done: fill and drain");
	endtask
	task automatic t_mark();
		fcp_host_i.push(36'h9_0000_0000, 4, 1'h0);
		fcp_host_i.pop(1, q);
		@(posedge ref_clk);
		mark <= 1'h1;
		@(posedge ref_clk);
		mark <= 1'h0;
		fcp_host_i.pop(2, q);
		@(posedge ref_clk);
		retransmit <= 1'h1;
		@(posedge ref_clk);
		retransmit <= 1'h0;
		fcp_host_i.pop(4, q);
		for (int i = 0; i < 4; i++)
			check(q[i], 36'h9_0000_0001 + (i < 3 ? i : 2));
		check(empty_flag_n, 1'h0);
		// drain emptied the buffer, the fourth read was refused
		axi_rd(`FCP_REG_STATUS);
		check(rd, (32'h1 << `FCP_EV_EMPTY) | (32'h1 << `FCP_EV_UNDERFLOW));
		$display("test done: mark and retransmit");
	endtask
	task automatic t_config();
		sync_rst(1'h1);
		@(posedge ref_clk);
		config_select_n <= 1'h0;
		fcp_host_i.push(36'hf_ffff_ff05, 2, 1'h0);
		fcp_host_i.pop(1, q);
		@(posedge ref_clk);
		config_select_n <= 1'h1;
		check(q[0], 36'h5);
		check(empty_flag_n, 1'h0);
		fcp_host_i.push(36'h7_7777_0000, 3, 1'h0);
		sync_rst(1'h0);
		axi_rd(`FCP_REG_OFFSETS);
		check(rd, 32'h0605);
		fcp_host_i.push(36'h0, 1, 1'h1);
		fcp_host_i.pop(1, q);
		check(q[0], 36'h7_7777_0000);
		fcp_host_i.shift(16'h0403, 16, 1'h1);
		fcp_host_i.shift(16'hffff, 4, 1'h0);
		axi_rd(`FCP_REG_OFFSETS);
		check(rd, 32'h0403);
		sync_rst(1'h1);
		axi_rd(`FCP_REG_OFFSETS);
		check(rd, {16'h0, `FCP_AF_DEFAULT, `FCP_AE_DEFAULT});
		output_enable_n <= 1'h1;
		repeat (2) @(negedge ref_clk);
		check(data_out_oe, 1'h0);
		$display("test done: config, resets, serial, output enable");
	endtask
	initial
	begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'h1;
		repeat (2) @(negedge ref_clk);
		check(flags, 4'h5);
		t_fill();
		t_mark();
		t_config();
		print_verdict();
	end
	// cut a hang well beyond the few hundred cycles the tests need
	initial
	begin
		#(50 * 5000);
		err_total++;
		print_verdict();
	end
endmodule
